// [hw/odc_octal_dac.sv]
// Operation
// R1: Special commands work in either mode.
// R2: Update-select loads selected outputs from registers.
// R3: Regulator field 10 enables, 00 disables.
// R4: First-channel write loads it, updates all.
// R5: First-channel write keeps the current mode.
// R6: Broadcast writes all registers and outputs.
// R7: Reset clears registers and outputs to zero.
// R8: Codes d,e,f power down with termination.
// R9: Low eight data bits select channels.
// R10: Powered channel off; bias off when all.
// R11: Power-down never alters stored channel data.
// R12: Link and data writes work while powered down.
// R13: Recovery ramps from zero within 20 us.
// R14: Host idles link quietly during power-down.
// R15: Sixteen-bit word, MSB first, code then data.
// R16: Data sampled on serial clock falling edge.
// R17: Command executes on frame select rising edge.
// R18: Codes 9/8 select through/register mode; register first.
// R19: Any output update wakes a powered channel.
// R20: Reserved regulator values keep regulator off.
module odc_octal_dac (
    input  wire logic                                 hclk,
    input  wire logic                                 hresetn,
    input  wire logic                                 hsel,
    input  wire logic [31:0]                          haddr,
    input  wire logic [1:0]                           htrans,
    input  wire logic                                 hwrite,
    input  wire logic [2:0]                           hsize,
    input  wire logic                                 hready,
    input  wire logic [31:0]                          hwdata,
    output logic      [31:0]                          hrdata,
    output logic                                      hreadyout,
    output logic                                      hresp,
    input  wire logic                                 sclk,
    input  wire logic                                 sync_n,
    input  wire logic                                 din,
    output odc_pkg::odc_codes_t                       dac_code,
    output logic      [odc_pkg::NUM_CH-1:0]           core_en,
    output logic      [odc_pkg::NUM_CH-1:0][1:0]      term,
    output logic                                      bias_en,
    output logic                                      reg_en,
    output logic                                      write_through_mode
);
    import odc_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYC);

    typedef struct packed {
        odc_dev_t          dev;
        logic              bias;
        logic              prev_sclk;
        logic              prev_sync_n;
        logic [15:0]       shift;
        logic [4:0]        bitcnt;
        logic              link_en;
        logic [15:0]       last_cmd;
        logic [7:0]        frames;
        odc_ahb_st_t       ahb;
        logic [7:0]        addr;
        logic [31:0]       rdata;
        logic [TICK_W-1:0] tick_cnt;
        logic              tick;
    } odc_top_t;

    odc_top_t  s;
    odc_top_t  next_s;
    odc_link_t lk;
    odc_cmd_t  word;
    logic      frame_fall;
    logic      sclk_fall;
    logic      exec_link;
    logic      cmd_wr;
    logic      accept;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic odc_codes_t lane_mask(logic [NUM_CH-1:0] sel);
        odc_codes_t m;
        m = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            m[i] = {DATA_W{sel[i]}};
        end
        return m;
    endfunction

    function automatic odc_dev_t apply_cmd(odc_dev_t d, odc_cmd_t c);
        odc_dev_t          r;
        logic [NUM_CH-1:0] wake;
        logic [2:0]        ch;
        r    = d;
        wake = '0;
        ch   = c.code[2:0];
        if (!c.code[3]) begin
            r.ctrl[ch] = c.data; // [R12]
            if (d.thru_mode) begin
                r.out[ch] = c.data;
                wake[ch]  = 1'b1; // [R19]
            end
        end else begin
            unique case (c.code) // [R1]
                CMD_REGS: r.thru_mode = 1'b0; // [R18]
                CMD_THRU: r.thru_mode = 1'b1; // [R18]
                CMD_UPD: begin
                    r.out    = (d.out & ~lane_mask(c.data[7:0]))
                             | (d.ctrl & lane_mask(c.data[7:0])); // [R2]
                    wake     = c.data[7:0];
                    // Only the enabling code turns the regulator on; reserved codes keep it off.
                    r.reg_en = (c.data[REG_SEL_MSB:REG_SEL_LSB] == REG_ENABLE_SEL); // [R3] [R20]
                end
                CMD_CH1: begin
                    r.ctrl[0] = c.data; // [R4]
                    r.out     = r.ctrl; // [R4] [R5]
                    wake      = '1;
                end
                CMD_BCAST: begin
                    r.ctrl = {NUM_CH{c.data}}; // [R6]
                    r.out  = {NUM_CH{c.data}}; // [R6]
                    wake   = '1;
                end
                default: begin
                    // Power-down: data and output codes stay untouched.
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (c.data[i]) begin
                            r.pd[i]   = 1'b1; // [R8] [R9] [R11]
                            r.term[i] = c.code[1:0]; // [R8]
                        end
                    end
                end
            endcase
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (wake[i]) begin
                r.pd[i]   = 1'b0; // [R19]
                r.term[i] = TERM_ACTIVE;
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] read_reg(odc_top_t st, logic [7:0] a);
        logic [7:0]  off;
        logic [31:0] v;
        off = a - ADDR_CHAN0;
        v   = '0;
        if (a == ADDR_CTRL) begin
            v = {31'h0000_0000, st.link_en};
        end else if (a == ADDR_CMD) begin
            v = {16'h0000, st.last_cmd};
        end else if (a == ADDR_STATUS) begin
            v = {8'h00, st.frames, st.dev.pd, 5'h00, st.bias, st.dev.reg_en, st.dev.thru_mode};
        end else if (a == ADDR_TERM) begin
            v = {16'h0000, st.dev.term};
        end else if (a >= ADDR_CHAN0 && a < ADDR_END) begin
            v = {4'h0, st.dev.out[off[4:2]], 4'h0, st.dev.ctrl[off[4:2]]};
        end
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Serial link sampling
    // ----------------------------------------------------------------
    odc_sync #(
        .W       (3),
        .RST_VAL (LINK_IDLE)
    ) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({sclk, sync_n, din}),
        .q     (lk)
    );

    assign word       = odc_cmd_t'(s.shift); // [R15]
    assign sclk_fall  = s.prev_sclk & ~lk.sclk;
    assign frame_fall = s.prev_sync_n & ~lk.sync_n;
    // Fewer than a whole word in a frame is a broken frame and is dropped.
    assign exec_link  = ~s.prev_sync_n & lk.sync_n & s.link_en
                      & (s.bitcnt >= 5'(WORD_BITS)); // [R17]
    assign cmd_wr     = (s.ahb == AHB_WR) && (s.addr == ADDR_CMD);
    assign accept     = hsel & hready & htrans[1];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s             = s;
        next_s.prev_sclk   = lk.sclk;
        next_s.prev_sync_n = lk.sync_n;

        if (frame_fall) begin
            next_s.bitcnt = '0;
        end
        if (sclk_fall && !lk.sync_n) begin
            next_s.shift = {s.shift[14:0], lk.din}; // [R16] [R15]
            if (s.bitcnt < 5'(WORD_BITS)) begin
                next_s.bitcnt = s.bitcnt + 5'd1;
            end
        end

        // A link command and a bus command in one cycle both execute, link first.
        if (exec_link) begin
            next_s.dev      = apply_cmd(next_s.dev, word); // [R17]
            next_s.last_cmd = s.shift;
            next_s.frames   = s.frames + 8'd1;
        end
        if (s.ahb == AHB_WR) begin
            if (s.addr == ADDR_CTRL) begin
                next_s.link_en = hwdata[0];
            end else if (cmd_wr) begin
                next_s.dev      = apply_cmd(next_s.dev, odc_cmd_t'(hwdata[15:0]));
                next_s.last_cmd = hwdata[15:0];
            end
        end
        next_s.bias = ~&next_s.dev.pd; // [R10]

        unique case (s.ahb)
            AHB_RD_WAIT: begin
                next_s.rdata = read_reg(s, s.addr);
                next_s.ahb   = AHB_RD_OUT;
            end
            default: begin
                next_s.ahb = AHB_IDLE;
                if (accept) begin
                    next_s.addr = haddr[7:0];
                    next_s.ahb  = hwrite ? AHB_WR : AHB_RD_WAIT;
                end
            end
        endcase

        next_s.tick = 1'b0;
        if (s.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
            next_s.tick_cnt = '0;
            next_s.tick     = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s             <= '0; // [R7]
            s.bias        <= 1'b1;
            s.prev_sync_n <= 1'b1;
            s.link_en     <= LINK_EN_RST;
            s.ahb         <= AHB_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Output stages
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        odc_ramp u_ramp (
            .clk          (hclk),
            .rst_n        (hresetn),
            .tick         (s.tick),
            .powered_down (s.dev.pd[g]),
            .target       (s.dev.out[g]),
            .code         (dac_code[g])
        );
    end

    assign core_en   = ~s.dev.pd; // [R10]
    assign term      = s.dev.term;
    assign bias_en   = s.bias;
    assign reg_en    = s.dev.reg_en;
    assign write_through_mode = s.dev.thru_mode;
    assign hrdata    = s.rdata;
    assign hreadyout = (s.ahb != AHB_RD_WAIT);
    assign hresp     = 1'b0;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_link_cmd(logic [3:0] c);
        exec_link && !cmd_wr && word.code == c;
    endsequence

    property p_shift;
        @(posedge hclk) disable iff (!hresetn)
        (sclk_fall && !lk.sync_n) |=> s.shift == {$past(s.shift[14:0]), $past(lk.din)};
    endproperty
    a_shift: assert property (p_shift) else $error("serial bit not shifted in"); // [R16]

    property p_thru_mode;
        @(posedge hclk) disable iff (!hresetn)
        s_link_cmd(CMD_THRU) |=> write_through_mode
            ##1 (write_through_mode || $past(exec_link) || $past(cmd_wr));
    endproperty
    a_thru_mode: assert property (p_thru_mode) else $error("write-through mode not set"); // [R18]

    property p_ch1_mode;
        @(posedge hclk) disable iff (!hresetn)
        s_link_cmd(CMD_CH1) |=> (write_through_mode == $past(write_through_mode))
                                && (s.dev.ctrl[0] == $past(word.data))
                                && (s.dev.out == s.dev.ctrl);
    endproperty
    a_ch1_mode: assert property (p_ch1_mode) else $error("first-channel write wrong"); // [R4] [R5]

    property p_bcast;
        @(posedge hclk) disable iff (!hresetn)
        s_link_cmd(CMD_BCAST) |=> (s.dev.ctrl == {NUM_CH{$past(word.data)}})
                                  && (s.dev.out == s.dev.ctrl) && (core_en == '1);
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast did not reach all channels"); // [R6]

    property p_update;
        @(posedge hclk) disable iff (!hresetn)
        s_link_cmd(CMD_UPD) |=>
            s.dev.out == (($past(s.dev.out) & ~lane_mask($past(word.data[7:0])))
                         | ($past(s.dev.ctrl) & lane_mask($past(word.data[7:0]))));
    endproperty
    a_update: assert property (p_update) else $error("update-select outputs wrong"); // [R2]

    property p_regulator;
        @(posedge hclk) disable iff (!hresetn)
        s_link_cmd(CMD_UPD) |=> reg_en == ($past(word.data[11:10]) == REG_ENABLE_SEL);
    endproperty
    a_regulator: assert property (p_regulator) else $error("regulator select wrong"); // [R3] [R20]

    property p_powerdown;
        @(posedge hclk) disable iff (!hresetn)
        (exec_link && !cmd_wr && word.code[3:2] == 2'b11 && word.code[1:0] != 2'b00)
        |=> (core_en == ($past(core_en) & ~$past(word.data[7:0])))
            && (s.dev.ctrl == $past(s.dev.ctrl)) && (s.dev.out == $past(s.dev.out));
    endproperty
    a_powerdown: assert property (p_powerdown) else $error("power-down selection wrong"); // [R8] [R9] [R11]

    property p_bias;
        @(posedge hclk) disable iff (!hresetn)
        bias_en == (core_en != '0);
    endproperty
    a_bias: assert property (p_bias) else $error("bias state disagrees with channels"); // [R10]

    property p_data_store;
        @(posedge hclk) disable iff (!hresetn)
        (exec_link && !cmd_wr && !word.code[3])
        |=> s.dev.ctrl[$past(word.code[2:0])] == $past(word.data);
    endproperty
    a_data_store: assert property (p_data_store) else $error("channel data not stored"); // [R12]

    property p_short_frame;
        @(posedge hclk) disable iff (!hresetn)
        (~s.prev_sync_n && lk.sync_n && s.bitcnt < 5'(WORD_BITS) && !cmd_wr)
        |=> $stable(s.dev);
    endproperty
    a_short_frame: assert property (p_short_frame) else $error("short frame executed"); // [R15]
endmodule

// [hw/odc_pkg.sv]
package odc_pkg;

    // ----------------------------------------------------------------
    // Device geometry and command word layout
    // ----------------------------------------------------------------
    localparam int NUM_CH    = 8;
    localparam int DATA_W    = 12;
    localparam int WORD_BITS = 16;

    localparam logic [3:0] CMD_REGS    = 4'h8;
    localparam logic [3:0] CMD_THRU    = 4'h9;
    localparam logic [3:0] CMD_UPD     = 4'ha;
    localparam logic [3:0] CMD_CH1     = 4'hb;
    localparam logic [3:0] CMD_BCAST   = 4'hc;
    localparam logic [3:0] CMD_PD_HIZ  = 4'hd;
    localparam logic [3:0] CMD_PD_100K = 4'he;
    localparam logic [3:0] CMD_PD_2K5  = 4'hf;

    localparam logic [1:0] REG_ENABLE_SEL = 2'b10;
    localparam int         REG_SEL_MSB    = 11;
    localparam int         REG_SEL_LSB    = 10;

    // Termination code equals the low two bits of the power-down command.
    localparam logic [1:0] TERM_ACTIVE = 2'b00;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CMD    = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TERM   = 8'h0c;
    localparam logic [7:0] ADDR_CHAN0  = 8'h10;
    localparam logic [7:0] ADDR_END    = 8'h30;

    localparam logic       LINK_EN_RST = 1'b1;
    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'b10;
    // Synchroniser reset value is the link at rest, so no false edge follows reset.
    localparam logic [2:0] LINK_IDLE   = 3'b110;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_MHZ     = 40;
    localparam int          RECOVER_US  = 20;
    localparam int          RECOVER_CYC = RECOVER_US * CLK_MHZ;
    localparam logic [12:0] RAMP_STEP   = 13'h0100;
    localparam int          RAMP_STEPS  = 4096 / 256;
    // Two spare tick periods keep a full-scale ramp inside the recovery bound.
    localparam int          TICK_CYC    = RECOVER_CYC / (RAMP_STEPS + 2);

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0]        code;
        logic [DATA_W-1:0] data;
    } odc_cmd_t;

    typedef struct packed {
        logic sclk;
        logic sync_n;
        logic din;
    } odc_link_t;

    typedef logic [NUM_CH-1:0][DATA_W-1:0] odc_codes_t;

    typedef struct packed {
        odc_codes_t             ctrl;
        odc_codes_t             out;
        logic                   thru_mode;
        logic                   reg_en;
        logic [NUM_CH-1:0]      pd;
        logic [NUM_CH-1:0][1:0] term;
    } odc_dev_t;

    typedef enum logic [3:0] {
        AHB_IDLE    = 4'b0001,
        AHB_WR      = 4'b0010,
        AHB_RD_WAIT = 4'b0100,
        AHB_RD_OUT  = 4'b1000
    } odc_ahb_st_t;

endpackage

// [hw/odc_sync.sv]
module odc_sync #(
    parameter int           W       = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import odc_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } odc_sync_st_t;

    odc_sync_st_t s;
    odc_sync_st_t next_s;

    always_comb begin
        next_s.meta   = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s.meta   <= RST_VAL;
            s.stable <= RST_VAL;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stable;
endmodule

// [hw/odc_ramp.sv]
module odc_ramp (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      tick,
    input  wire logic                      powered_down,
    input  wire logic [odc_pkg::DATA_W-1:0] target,
    output logic      [odc_pkg::DATA_W-1:0] code
);
    import odc_pkg::*;

    typedef struct packed {
        logic              prev_pd;
        logic              ramping;
        logic [DATA_W-1:0] code;
    } odc_ramp_st_t;

    odc_ramp_st_t s;
    odc_ramp_st_t next_s;
    logic [12:0]  sum;

    always_comb begin
        next_s         = s;
        next_s.prev_pd = powered_down;
        sum            = {1'b0, s.code} + RAMP_STEP;
        if (powered_down) begin
            next_s.code    = '0;
            next_s.ramping = 1'b0;
        end else if (s.prev_pd) begin
            next_s.ramping = 1'b1; // [R13]
        end else if (s.ramping) begin
            if (tick) begin
                // A shrinking target during the ramp simply ends it early.
                if (sum >= {1'b0, target}) begin
                    next_s.code    = target;
                    next_s.ramping = 1'b0;
                end else begin
                    next_s.code = sum[DATA_W-1:0]; // [R13]
                end
            end
        end else begin
            next_s.code = target;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign code = s.code;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    localparam int REC_MAX = RECOVER_CYC;

    sequence s_wake;
        $fell(powered_down);
    endsequence

    property p_recover;
        @(posedge clk) disable iff (!rst_n)
        s_wake |-> ##[1:REC_MAX] (code == target || powered_down);
    endproperty
    a_recover: assert property (p_recover) else $error("channel did not recover in time"); // [R13]

    property p_pd_zero;
        @(posedge clk) disable iff (!rst_n)
        powered_down |=> (code == '0);
    endproperty
    a_pd_zero: assert property (p_pd_zero) else $error("powered-down output not at zero"); // [R10]
endmodule

// [verification/odc_host_model.sv]
module odc_host_model (
    output logic sclk,
    output logic sync_n,
    output logic din
);
    timeunit 1ns;
    timeprecision 1ps;

    // The link clock parks high outside frames, so every bit costs one falling edge.
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        din = 1'b0;
    end

    // A count below sixteen sends only the leading bits, making a broken frame.
    task automatic shift(input logic [15:0] w, input int n = 16);
        sync_n <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            din <= w[i];
            #100 sclk <= 1'b0;
            #100 sclk <= 1'b1;
        end
        #100 din <= 1'b0;
    endtask

    task automatic close();
        sync_n <= 1'b1;
    endtask
endmodule

// [verification/tb_octal_dac_command_decoder.sv]
module tb_octal_dac_command_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import odc_pkg::*;

    typedef struct packed {
        logic [15:0] c;
        logic [7:0]  en;
    } odc_row_t;

    logic             hclk = 1'b0;
    logic             hresetn = 1'b0;
    logic             hsel = 1'b0;
    logic             hwrite = 1'b0;
    logic [1:0]       htrans = 2'h0;
    logic [31:0]      haddr = 32'h0;
    logic [31:0]      hwdata = 32'h0;
    logic [31:0]      hrdata;
    logic [31:0]      rd;
    logic             hreadyout, hresp, sclk, sync_n, din, bias_en, reg_en, ew, er;
    logic             write_through_mode;
    logic [7:0]       core_en, pd;
    logic [7:0][1:0]  term, tm;
    odc_codes_t       dac_code, ctl, out;
    int               n_errors = 0;
    int               comparisons = 0;
    int               cyc = 0;
    odc_row_t         rows [16] = '{
        '{16'h0123, 8'hff}, '{16'h7abc, 8'hff}, '{16'ha881, 8'hff}, '{16'hd003, 8'hfc},
        '{16'he0f0, 8'h0c}, '{16'hf00c, 8'h00}, '{16'h1555, 8'h00}, '{16'h9000, 8'h00},
        '{16'h2777, 8'h04}, '{16'ha402, 8'h06}, '{16'hb321, 8'hff}, '{16'h8000, 8'hff},
        '{16'hcfff, 8'hff}, '{16'hbabc, 8'hff}, '{16'ha800, 8'hff}, '{16'hac00, 8'hff}
    };

    always #12.5 hclk = ~hclk;

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            test_done();
        end
    end

    odc_octal_dac i_odc_octal_dac (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .sclk,
        .sync_n, .din, .dac_code, .core_en, .term, .bias_en, .reg_en, .write_through_mode);
    odc_host_model i_odc_host_model (.sclk, .sync_n, .din);

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_bits(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_code(input odc_codes_t g, input odc_codes_t e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: codes %h exp %h", $time, g, e);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Reference state: what every command should leave behind.
    task automatic mdl(input logic [15:0] c);
        logic [7:0] up;
        up = 8'h00;
        case (c[15:12])
            4'h8: ew = 1'b0;
            4'h9: ew = 1'b1;
            4'ha: begin
                up = c[7:0];
                er = (c[11:10] == 2'b10);
            end
            4'hb: begin
                ctl[0] = c[11:0];
                up = 8'hff;
            end
            4'hc: begin
                ctl = {8{c[11:0]}};
                up = 8'hff;
            end
            4'hd, 4'he, 4'hf: begin
                pd |= c[7:0];
                for (int i = 0; i < 8; i++) if (c[i]) tm[i] = c[13:12];
            end
            default: begin
                ctl[c[14:12]] = c[11:0];
                up[c[14:12]] = ew;
            end
        endcase
        for (int i = 0; i < 8; i++) if (up[i]) begin
            out[i] = ctl[i];
            pd[i] = 1'b0;
            tm[i] = 2'b00;
        end
    endtask

    task automatic check_all();
        odc_codes_t ec;
        for (int i = 0; i < 8; i++) ec[i] = pd[i] ? 12'h000 : out[i];
        chk_code(dac_code, ec);
        chk_bits(32'(term), 32'(tm));
        chk_bits(32'(bias_en), 32'(pd != 8'hff));
        chk_bits(32'(reg_en), 32'(er));
        chk_bits(32'(write_through_mode), 32'(ew));
    endtask

    task automatic frame(input logic [15:0] c);
        i_odc_host_model.shift(c);
        i_odc_host_model.close();
        mdl(c);
        // Covers the sync delay plus the longest recovery ramp.
        repeat (810) @(posedge hclk);
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        ctl = '0;
        out = '0;
        pd = 8'h00;
        tm = '0;
        ew = 1'b0;
        er = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        check_all();
        ahb(1'b0, 8'h08, 32'h0);
        chk_bits(rd, 32'h4);
        chk_bits(32'(hresp), 32'h0);
        ahb(1'b0, 8'h00, 32'h0);
        chk_bits(rd, 32'h1);
        foreach (rows[k]) begin
            frame(rows[k].c);
            check_all();
            chk_bits(32'(core_en), 32'(rows[k].en));
        end
        i_odc_host_model.shift(16'h9000);
        repeat (20) @(posedge hclk);
        chk_bits(32'(write_through_mode), 32'h0);
        i_odc_host_model.close();
        mdl(16'h9000);
        repeat (10) @(posedge hclk);
        chk_bits(32'(write_through_mode), 32'h1);
        ahb(1'b1, 8'h04, 32'hd001);
        ahb(1'b1, 8'h04, 32'ha001);
        mdl(16'hd001);
        mdl(16'ha001);
        repeat (20) @(posedge hclk);
        chk_bits(32'(dac_code[0] < 12'habc), 32'h1);
        repeat (810) @(posedge hclk);
        check_all();
        ahb(1'b1, 8'h04, 32'hc0aa);
        mdl(16'hc0aa);
        repeat (810) @(posedge hclk);
        check_all();
        ahb(1'b0, 8'h10, 32'h0);
        chk_bits(rd, 32'h00aa00aa);
        ahb(1'b0, 8'h40, 32'h0);
        chk_bits(rd, 32'h0);
        // Eight bits only: executing it would write channel 0 in write-through mode.
        i_odc_host_model.shift(16'h8000, 8);
        i_odc_host_model.close();
        repeat (20) @(posedge hclk);
        check_all();
        ahb(1'b1, 8'h00, 32'h0);
        frame(16'hc111);
        mdl(16'hc0aa);
        check_all();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk_code(dac_code, '0);
        chk_bits(32'(write_through_mode), 32'h0);
        test_done();
    end
endmodule
